// >>> css_pkg.sv
// Shared constants and types for the capacitive sensing status and settings block
// What this block does
// - Movement flag follows detected movement
// - Latch flag: set on movement, cleared by time-out
// - Presence flag follows presence threshold, debounced over two measurements
// - Contact flag is the main activation
// - Hard reset sets reset flag; software clears
// - Busy flag high during calibration
// - Halt equals presence or undebounced contact
// - Low-power flag: sleep interval set and no movement, presence or contact
// - Motion intensity averages movement pulses
// - Reference tracks drift, frozen while halted
// - Reseed copies counts, recalibrates if outside
// - Recalibrate bit forces calibration, self-clears
// - Direction bit adds count rises to presence
// - Reseed limit unit seconds or minutes
// - Halt time-out 2 or 20 seconds
// - Manual-only mode: time-out just reseeds
// - Calibration target forwarded as setting times 8, up to 2040
// - Thresholds are reference times ratio/256
// - Contact ratio 15 or more: undebounced
// - Reseed limit 0xFF disables auto reseed
// - Forced mode: movement asserts output
// - Output held while movement, time-out releases
package css_pkg;
  // Register offsets
  localparam logic [7:0] OFF_ID = 8'h00;
  localparam logic [7:0] OFF_REV = 8'h01;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_MOTION = 8'h41;
  localparam logic [7:0] OFF_CNT = 8'h42;
  localparam logic [7:0] OFF_REF = 8'h83;
  localparam logic [7:0] OFF_CLIM = 8'h90;
  localparam logic [7:0] OFF_MULT = 8'hC4;
  localparam logic [7:0] OFF_COMP = 8'hC5;
  localparam logic [7:0] OFF_SC0 = 8'hC6;
  localparam logic [7:0] OFF_SC1 = 8'hC7;
  localparam logic [7:0] OFF_SC2 = 8'hC8;
  localparam logic [7:0] OFF_TGT = 8'hC9;
  localparam logic [7:0] OFF_SLEEP = 8'hCA;
  localparam logic [7:0] OFF_PR = 8'hCB;
  localparam logic [7:0] OFF_CR = 8'hCC;
  localparam logic [7:0] OFF_MR = 8'hCD;
  localparam logic [7:0] OFF_LIM = 8'hCE;
  // Status flag positions
  localparam int B_MOV = 7;
  localparam int B_LATCH = 6;
  localparam int B_PROX = 5;
  localparam int B_CONT = 4;
  localparam int B_SHRST = 3;
  localparam int B_BUSY = 2;
  localparam int B_HALT = 1;
  localparam int B_LP = 0;
  // Control field positions
  localparam int B_RESEED = 5;
  localparam int B_RECAL = 4;
  localparam int B_DIR = 3;
  localparam int B_MINUTES = 7;
  localparam int B_LONGHALT = 7;
  localparam int B_MANCAL = 1;
  // User interface codes in sensing_control_1 bits 2-0
  localparam logic [2:0] UI_LATCH = 3'h1;
  localparam logic [2:0] UI_FORCED = 3'h2;
  // Reset value, auto-reseed off code, undebounced contact ratio
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] LIM_OFF = 8'hFF;
  localparam logic [7:0] CR_UNDEB = 8'h0F;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned SEC_CYC_DEF = TICK_S * 1_000_000_000 / CLK_PERIOD_NS;
  localparam int PRESC_W = 27;
  localparam logic [4:0] HALT_SHORT_S = 5'd2;
  localparam logic [4:0] HALT_LONG_S = 5'd20;
  localparam logic [5:0] SEC_PER_MIN = 6'd60;
  localparam logic [2:0] MOV_WIN_LAST = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ADDR = 7'h02, ST_AACK = 7'h04, ST_WR = 7'h08,
    ST_WACK = 7'h10, ST_RD = 7'h20, ST_RACK = 7'h40
  } css_st_t;

  typedef struct packed {
    logic valid;
    logic move;
    logic [15:0] count;
  } css_meas_t;

  typedef struct packed {
    logic done;
    logic [7:0] mult;
    logic [7:0] comp;
  } css_cal_t;

  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    css_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic oe_n;
    logic [7:0] mult, comp, sc0, sc1, sc2, tgt, sleep, pr, cr, mr, lim;
    logic mov, latch, prox, contact, showrst, busy, halt, lp;
    logic pdeb, cdeb, mseen, act;
    logic [7:0] intensity;
    logic [10:0] macc;
    logic [2:0] win;
    logic [15:0] count, refv, presence_ratio_setting, cth;
    logic [PRESC_W-1:0] presc;
    logic [5:0] mcnt;
    logic [4:0] hsec;
    logic [7:0] rs;
  } css_state_t;
endpackage : css_pkg

// >>> css_regs.sv
// Register bank and detection state of the capacitive sensing channel
`timescale 1ns/10ps
module css_regs import css_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,   // Arbitrary bus address
  parameter logic [7:0] PRODUCT_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] FW_REV = 8'hA5,     // Arbitrary value
  parameter int unsigned SEC_CYC = SEC_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire css_meas_t meas,
  input wire css_cal_t cal,
  output logic cal_busy,
  output logic [10:0] cal_target,
  output logic act_out
);
  css_state_t s;
  css_state_t n;
  logic scl_r, scl_f, start_c, stop_c, wr_en, sec_tick, unit_tick;
  logic prox_raw, cont_raw, undeb, timeout, auto_rs, reseed_w, recal_w, reseed_any, oob;
  logic [4:0] hlim;
  logic [15:0] tgt16;

  // Counts plus threshold still below the reference
  function automatic logic below(input logic [15:0] a, input logic [15:0] b,
                                 input logic [15:0] t);
    return ({1'b0, a} + {1'b0, t}) < {1'b0, b};
  endfunction : below

  // Threshold in counts from reference and ratio
  function automatic logic [15:0] thr(input logic [15:0] r, input logic [7:0] k);
    logic [23:0] p;
    p = {8'h00, r} * {16'h0000, k};
    return p[23:8];
  endfunction : thr

  // Read mux; 16-bit values low byte first
  function automatic logic [7:0] rd_byte(input css_state_t q, input logic [7:0] a);
    logic [7:0] f;
    logic [15:0] lim;
    f = 8'h00;
    f[B_MOV] = q.mov;
    f[B_LATCH] = q.latch;
    f[B_PROX] = q.prox;
    f[B_CONT] = q.contact;
    f[B_SHRST] = q.showrst;
    f[B_BUSY] = q.busy;
    f[B_HALT] = q.halt;
    f[B_LP] = q.lp;
    lim = q.refv - q.cth;
    case (a)
      OFF_ID: return PRODUCT_ID;
      OFF_REV: return FW_REV;
      OFF_FLAGS: return f;
      OFF_MOTION: return q.intensity;
      OFF_CNT: return q.count[7:0];
      OFF_CNT + 8'h01: return q.count[15:8];
      OFF_REF: return q.refv[7:0];
      OFF_REF + 8'h01: return q.refv[15:8];
      OFF_CLIM: return lim[7:0];
      OFF_CLIM + 8'h01: return lim[15:8];
      OFF_MULT: return q.mult;
      OFF_COMP: return q.comp;
      OFF_SC0: return q.sc0;
      OFF_SC1: return q.sc1;
      OFF_SC2: return q.sc2;
      OFF_TGT: return q.tgt;
      OFF_SLEEP: return q.sleep;
      OFF_PR: return q.pr;
      OFF_CR: return q.cr;
      OFF_MR: return q.mr;
      OFF_LIM: return q.lim;
      default: return 8'h00;
    endcase
  endfunction : rd_byte

  // Bus edges come from the second and third sync stages only
  always_comb begin
    scl_r = s.scl[1] & ~s.scl[2];
    scl_f = ~s.scl[1] & s.scl[2];
    start_c = s.scl[1] & s.sda[2] & ~s.sda[1];
    stop_c = s.scl[1] & ~s.sda[2] & s.sda[1];
    sec_tick = s.presc == PRESC_W'(SEC_CYC - 1);
    unit_tick = s.sc1[B_MINUTES] ? (sec_tick && s.mcnt == SEC_PER_MIN - 6'd1) : sec_tick;
    hlim = s.sc2[B_LONGHALT] ? HALT_LONG_S : HALT_SHORT_S;
    tgt16 = {5'h00, s.tgt, 3'h0};
    oob = below(s.count, tgt16, {3'h0, tgt16[15:3]}) |
          below(tgt16, s.count, {3'h0, tgt16[15:3]});
    prox_raw = below(meas.count, s.refv, s.presence_ratio_setting) |
               (s.sc0[B_DIR] & below(s.refv, meas.count, s.presence_ratio_setting));
    cont_raw = below(meas.count, s.refv, s.cth);
    undeb = s.cr >= CR_UNDEB;
    // No-movement time-out only matters while something is held
    timeout = sec_tick & ~meas.move & (s.halt | s.act | s.latch) &
              (s.hsec == hlim - 5'd1);
    auto_rs = s.halt & unit_tick & (s.lim != LIM_OFF) &
              ({1'b0, s.rs} + 9'd1 >= {1'b0, s.lim});
  end

  // Next-state logic: bus, measurement, timers, calibration, writes
  always_comb begin
    n = s;
    wr_en = 1'b0;
    n.scl = {s.scl[1:0], scl_i};
    n.sda = {s.sda[1:0], sda_i};
    if (stop_c) begin
      n.st = ST_IDLE;
      n.oe_n = 1'b1;
    end else if (start_c) begin
      n.st = ST_ADDR;
      n.cnt = 4'h0;
      n.oe_n = 1'b1;
    end else begin
      unique case (s.st)
        ST_IDLE: n.oe_n = 1'b1;
        ST_ADDR, ST_WR: begin
          if (scl_r) begin
            n.sh = {s.sh[6:0], s.sda[1]};
            n.cnt = s.cnt + 4'h1;
          end else if (scl_f && s.cnt == 4'h8) begin
            n.cnt = 4'h0;
            if (s.st == ST_ADDR) begin
              n.st = (s.sh[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
              n.oe_n = (s.sh[7:1] != DEV_ADDR);
              n.rw = s.sh[0];
            end else begin
              // First written byte is the register pointer
              if (s.first) begin
                n.ptr = s.sh;
              end else begin
                wr_en = 1'b1;
                n.ptr = s.ptr + 8'h01;
              end
              n.first = 1'b0;
              n.oe_n = 1'b0;
              n.st = ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_f) begin
            n.cnt = 4'h0;
            if (s.rw) begin
              n.sh = rd_byte(s, s.ptr);
              n.oe_n = n.sh[7];
              n.st = ST_RD;
            end else begin
              n.oe_n = 1'b1;
              n.first = 1'b1;
              n.st = ST_WR;
            end
          end
        end
        ST_WACK: begin
          if (scl_f) begin
            n.oe_n = 1'b1;
            n.st = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_r) begin
            n.cnt = s.cnt + 4'h1;
          end else if (scl_f) begin
            if (s.cnt == 4'h8) begin
              n.oe_n = 1'b1;
              n.st = ST_RACK;
            end else begin
              n.oe_n = s.sh[3'h7 - s.cnt[2:0]];
            end
          end
        end
        ST_RACK: begin
          if (scl_r) begin
            n.nack = s.sda[1];
          end else if (scl_f) begin
            if (s.nack) begin
              n.st = ST_IDLE;
            end else begin
              n.ptr = s.ptr + 8'h01;
              n.sh = rd_byte(s, n.ptr);
              n.oe_n = n.sh[7];
              n.cnt = 4'h0;
              n.st = ST_RD;
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
          n.oe_n = 1'b1;
        end
      endcase
    end

    // Second and minute prescalers
    n.presc = sec_tick ? '0 : s.presc + PRESC_W'(1);
    if (sec_tick) begin
      n.mcnt = (s.mcnt == SEC_PER_MIN - 6'd1) ? 6'd0 : s.mcnt + 6'd1;
    end

    // Motion pulses summed over a window of measurements
    if (meas.move && s.macc != 11'h7FF) begin
      n.macc = s.macc + 11'h001;
    end
    if (meas.move) begin
      n.mseen = 1'b1;
    end

    // Flags sampled once per measurement so a read sees one snapshot
    if (meas.valid) begin
      n.count = meas.count;
      n.mov = s.mseen | meas.move;
      n.mseen = 1'b0;
      n.pdeb = prox_raw;
      n.cdeb = cont_raw;
      n.prox = prox_raw & s.pdeb;
      n.contact = cont_raw & (s.cdeb | undeb);
      n.halt = (prox_raw & s.pdeb) | cont_raw;
      n.lp = (s.sleep != 8'h00) & ~n.prox & ~n.contact & ~n.mov;
      if (s.sc1[2:0] == UI_LATCH && n.mov) begin
        n.latch = 1'b1;
      end
      // Slow drift tracking, one count per measurement
      if (!s.halt && meas.count > s.refv) begin
        n.refv = s.refv + 16'h0001;
      end else if (!s.halt && meas.count < s.refv) begin
        n.refv = s.refv - 16'h0001;
      end
      n.win = s.win + 3'h1;
      if (s.win == MOV_WIN_LAST) begin
        n.intensity = s.macc[10:3];
        n.macc = 11'h000;
      end
    end

    // No-movement timer restarts on every movement
    if (meas.move || timeout || !(s.halt | s.act | s.latch)) begin
      n.hsec = 5'd0;
    end else if (sec_tick) begin
      n.hsec = s.hsec + 5'd1;
    end
    if (!s.halt || auto_rs) begin
      n.rs = 8'h00;
    end else if (unit_tick) begin
      n.rs = s.rs + 8'h01;
    end
    if (timeout) begin
      n.latch = 1'b0;
    end
    // Contact activates; movement holds; forced mode follows movement
    n.act = n.contact | (s.act & ~timeout) |
            (s.sc1[2:0] == UI_FORCED & meas.move);

    // Calibration result freezes thresholds
    if (s.busy && cal.done) begin
      n.busy = 1'b0;
      n.sc0[B_RECAL] = 1'b0;
      n.mult = cal.mult;
      n.comp = cal.comp;
      n.refv = s.count;
      n.presence_ratio_setting = thr(s.count, s.pr);
      n.cth = thr(s.count, s.cr);
    end

    // Reseed after the calibration result, so a new recalibration request wins
    reseed_w = wr_en && s.ptr == OFF_SC0 && s.sh[B_RESEED];
    recal_w = wr_en && s.ptr == OFF_SC0 && s.sh[B_RECAL];
    reseed_any = reseed_w | timeout | auto_rs;
    if (reseed_any) begin
      n.refv = s.count;
      n.halt = 1'b0;
      // Presence is the halt indicator, so it drops and re-debounces with it
      n.prox = 1'b0;
      n.pdeb = 1'b0;
      if (!s.sc2[B_MANCAL] && oob) begin
        n.busy = 1'b1;
      end
    end

    // Software writes last, so a fresh recalibrate request wins
    if (wr_en) begin
      case (s.ptr)
        OFF_FLAGS: if (!s.sh[B_SHRST]) n.showrst = 1'b0;
        OFF_MULT: n.mult = s.sh;
        OFF_COMP: n.comp = s.sh;
        OFF_SC0: n.sc0 = {s.sh[7:6], 1'b0, n.sc0[B_RECAL] | s.sh[B_RECAL], s.sh[3:0]};
        OFF_SC1: n.sc1 = s.sh;
        OFF_SC2: n.sc2 = s.sh;
        OFF_TGT: n.tgt = s.sh;
        OFF_SLEEP: begin
          n.sleep = s.sh;
          n.lp = n.lp & (s.sh != 8'h00);
        end
        OFF_PR: n.pr = s.sh;
        OFF_CR: n.cr = s.sh;
        OFF_MR: n.mr = s.sh;
        OFF_LIM: n.lim = s.sh;
        default: ;
      endcase
    end
    if (recal_w) begin
      n.busy = 1'b1;
    end

    // Soft reset keeps settings and the movement latch
    if (soft_rst) begin
      n.st = ST_IDLE;
      n.oe_n = 1'b1;
      n.mov = 1'b0;
      n.prox = 1'b0;
      n.contact = 1'b0;
      n.halt = 1'b0;
      n.lp = 1'b0;
      n.act = 1'b0;
      n.hsec = 5'd0;
      n.rs = 8'h00;
      n.busy = 1'b1;
      n.latch = s.latch;
    end

    // Hard reset; calibration starts right after it
    if (rst) begin
      n = '0;
      n.scl = 3'h7;
      n.sda = 3'h7;
      n.st = ST_IDLE;
      n.oe_n = 1'b1;
      n.showrst = 1'b1;
      n.busy = 1'b1;
      n.lim = CFG_RST;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  // Open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_n = s.oe_n;
  assign cal_busy = s.busy;
  assign cal_target = {s.tgt, 3'h0};
  assign act_out = s.act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_move_flag: assert property (
    meas.valid && meas.move && !soft_rst |=> s.mov)
    else $error("movement flag not set");
  a_latch_soft: assert property (
    soft_rst |=> s.latch == $past(s.latch))
    else $error("soft reset changed latch");
  a_show_reset: assert property (
    $past(rst) |-> s.showrst)
    else $error("reset flag missing after reset");
  a_cal_end: assert property (
    s.busy && cal.done && !recal_w && !reseed_any && !soft_rst |=> !cal_busy && !s.sc0[B_RECAL])
    else $error("calibration did not end");
  a_halt_prox: assert property (
    s.prox |-> s.halt)
    else $error("presence without halt");
  a_ref_frozen: assert property (
    s.halt && !reseed_any && !cal.done |=> s.refv == $past(s.refv))
    else $error("reference moved while halted");
  a_reseed_copy: assert property (
    reseed_any && !cal.done && !soft_rst |=> s.refv == $past(s.count))
    else $error("reseed did not copy counts");
  a_forced_move: assert property (
    s.sc1[2:0] == UI_FORCED && meas.move && !soft_rst |=> act_out)
    else $error("forced output missed movement");
  a_lp_idle: assert property (
    s.lp |-> !s.prox && !s.contact && s.sleep != 8'h00)
    else $error("low-power flag with activity");
  a_undeb_contact: assert property (
    meas.valid && cont_raw && undeb && !soft_rst |=> s.contact)
    else $error("undebounced contact missed");
endmodule : css_regs

// >>> css_regs_note_end.sv
// Empty: all logic of the block lives in css_regs.sv

// >>> css_host.sv
// Host bus master model that reaches the register bank over the two-wire pins
`timescale 1ns/10ps
module css_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv
);
  // Bus idles released, the pull-up holds both lines high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit slot of 16 clocks: data moves early in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge clk);
    sda_drv <= b;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    r = sda_in;
    scl <= 1'b0;
  endtask : bit_io
  // Start or repeated start: data falls while the clock is high
  task automatic start;
    repeat (2) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (8) @(posedge clk);
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    repeat (2) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop
  // Byte out, most significant bit first, then the acknowledge slot is released
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : tx
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask : rx
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] v,
                    output logic ack);
    logic a;
    start();
    tx({dev, 1'b0}, ack);
    tx(p, a);
    tx(v, a);
    stop();
  endtask : wr
  // Pointer write, repeated start, then n bytes low byte first; the last one is not acked
  task automatic rd(input logic [6:0] dev, input logic [7:0] p, input int n,
                    output logic [15:0] v, output logic ack);
    logic a;
    v = 16'h0000;
    start();
    tx({dev, 1'b0}, ack);
    tx(p, a);
    start();
    tx({dev, 1'b1}, a);
    for (int k = 0; k < n; k++) rx(k == n - 1, v[8*k+:8]);
    stop();
  endtask : rd
endmodule : css_host

// >>> test_css_regs.sv
// Self-checking bench for the capacitive sensing status and settings block
`timescale 1ns/10ps
module test_css_regs import css_pkg::*; ;
  localparam int unsigned SC = 2000; // Cycles per second, shortened to keep time-outs short
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary bus address
  localparam logic [7:0] PID = 8'h5A; // Arbitrary value
  localparam logic [7:0] FWR = 8'hA5; // Arbitrary value
  logic clk = 1'b0;
  logic rst, soft_rst, scl, sda_drv, sda_line, sda_o, sda_oe_n, cal_busy, act_out, ack;
  logic [10:0] cal_target;
  logic [15:0] d;
  css_meas_t meas;
  css_cal_t cal;
  int errors, n_checks, cyc;
  // Open drain line with pull-up: low when either party pulls
  assign sda_line = sda_drv & (sda_oe_n | sda_o);
  css_regs #(.DEV_ADDR(DEV), .PRODUCT_ID(PID), .FW_REV(FWR), .SEC_CYC(SC)) u_css_regs (
    .clk(clk), .rst(rst), .soft_rst(soft_rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .meas(meas), .cal(cal), .cal_busy(cal_busy),
    .cal_target(cal_target), .act_out(act_out));
  css_host u_css_host (.clk(clk), .sda_in(sda_line), .scl(scl), .sda_drv(sda_drv));
  always #5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Hang guard: the whole sequence needs a little over half of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic rchk(input logic [7:0] p, input int n, input logic [15:0] e, input string w);
    u_css_host.rd(DEV, p, n, d, ack);
    check(w, d, e);
  endtask : rchk
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    u_css_host.wr(DEV, p, v, ack);
    check("write ack", ack, 1'b1);
  endtask : wr
  // Movement starts a cycle ahead and stays through the completed measurement
  task automatic measure(input logic [15:0] c, input logic mv);
    @(posedge clk);
    meas.move <= mv;
    @(posedge clk);
    meas <= '{1'b1, mv, c};
    @(posedge clk);
    meas <= '{1'b0, 1'b0, c};
  endtask : measure
  task automatic calib(input logic [7:0] m, input logic [7:0] c);
    @(posedge clk);
    cal <= '{1'b1, m, c};
    @(posedge clk);
    cal.done <= 1'b0;
    @(posedge clk);
  endtask : calib
  initial begin
    rst = 1'b1;
    soft_rst = 1'b0;
    meas = '0;
    cal = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // After hard reset: show-reset and busy, identity, refused accesses
    check("cal_busy", cal_busy, 1'b1);
    rchk(OFF_FLAGS, 1, 16'h000C, "flags");
    wr(OFF_ID, 8'h00);
    rchk(OFF_ID, 1, PID, "product_id");
    rchk(OFF_REV, 1, FWR, "firmware_revision");
    rchk(8'h20, 1, 16'h0000, "unmapped");
    u_css_host.rd(7'h2B, OFF_ID, 1, d, ack);
    check("foreign address ack", ack, 1'b0);
    // Settings, then calibration at a 1600 count target
    wr(OFF_LIM, LIM_OFF);
    rchk(OFF_LIM, 1, 16'h00FF, "recal_time_limit");
    wr(OFF_PR, 8'h04);
    wr(OFF_CR, 8'h08);
    wr(OFF_SC2, 8'h02);
    wr(OFF_TGT, 8'hC8);
    check("cal_target", cal_target, 11'h640);
    measure(16'h0640, 1'b0);
    calib(8'h3C, 8'h81);
    check("cal_busy", cal_busy, 1'b0);
    rchk(OFF_MULT, 1, 16'h003C, "gain_multipliers");
    rchk(OFF_COMP, 1, 16'h0081, "gain_offset_value");
    rchk(OFF_CNT, 2, 16'h0640, "filtered_count");
    rchk(OFF_CLIM, 2, 16'h060E, "contact_limit_value");
    wr(OFF_FLAGS, 8'h00);
    rchk(OFF_FLAGS, 1, 16'h0000, "flags");
    // Rise in counts is ignored in decrease-only mode, a fall of 30 trips presence
    measure(16'h0660, 1'b0);
    measure(16'h0660, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0000, "flags rise");
    measure(16'h0622, 1'b0);
    measure(16'h0622, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0022, "flags presence");
    rchk(OFF_REF, 2, 16'h0640, "reference frozen");
    measure(16'h0622, 1'b1);
    repeat (SC) @(posedge clk);
    rchk(OFF_FLAGS, 1, 16'h00A2, "flags movement");
    measure(16'h0622, 1'b0);
    repeat (2 * SC) @(posedge clk);
    measure(16'h0622, 1'b0);
    measure(16'h0622, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0000, "flags after time-out");
    rchk(OFF_REF, 2, 16'h0622, "reference reseeded");
    check("cal_busy", cal_busy, 1'b0);
    // Low-power flag follows the sleep interval
    wr(OFF_SLEEP, 8'h01);
    measure(16'h0622, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0001, "flags low power");
    wr(OFF_SLEEP, 8'h00);
    measure(16'h0622, 1'b0);
    // Recalibrate command holds busy until done, then clears itself
    wr(OFF_SC0, 8'h10);
    check("cal_busy", cal_busy, 1'b1);
    rchk(OFF_FLAGS, 1, 16'h0004, "flags busy");
    measure(16'h0650, 1'b0);
    calib(8'h3D, 8'h82);
    rchk(OFF_SC0, 1, 16'h0000, "recal bit");
    rchk(OFF_REF, 2, 16'h0650, "reference calibrated");
    measure(16'h0630, 1'b0);
    wr(OFF_SC0, 8'h20);
    rchk(OFF_REF, 2, 16'h0630, "reference reseed");
    check("cal_busy", cal_busy, 1'b0);
    // Movement latch survives a soft reset and falls on the no-movement time-out
    wr(OFF_SC1, {5'h00, UI_LATCH});
    measure(16'h0630, 1'b1);
    rchk(OFF_FLAGS, 1, 16'h00C0, "flags latch");
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rchk(OFF_FLAGS, 1, 16'h0044, "flags soft reset");
    calib(8'h3D, 8'h82);
    repeat (3 * SC) @(posedge clk);
    rchk(OFF_FLAGS, 1, 16'h0000, "flags latch time-out");
    // Forced output: movement asserts it, the time-out releases it, a second movement asserts it again, the next time-out releases it
    wr(OFF_SC1, {5'h00, UI_FORCED});
    measure(16'h0630, 1'b1);
    repeat (4) @(posedge clk);
    check("act_out", act_out, 1'b1);
    repeat (SC + SC / 2) @(posedge clk);
    measure(16'h0630, 1'b1);
    repeat (SC * 9 / 10) @(posedge clk);
    check("act_out held", act_out, 1'b1);
    for (int i = 0; i < 2 * SC && act_out !== 1'b0; i++) @(posedge clk);
    check("act_out released", act_out, 1'b0);
    // Contact in the default interface is the activation
    wr(OFF_SC1, 8'h00);
    measure(16'h05F0, 1'b0);
    measure(16'h05F0, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0032, "flags contact");
    check("act_out contact", act_out, 1'b1);
    // Contact ratio of 15 or more: one measurement trips contact, halt without presence
    wr(OFF_CR, CR_UNDEB);
    measure(16'h0630, 1'b0);
    measure(16'h05F0, 1'b0);
    rchk(OFF_FLAGS, 1, 16'h0012, "flags undebounced");
    // With automatic calibration on, a reseed far from the target recalibrates
    wr(OFF_SC2, 8'h00);
    measure(16'h0500, 1'b0);
    wr(OFF_SC0, 8'h20);
    check("cal_busy far reseed", cal_busy, 1'b1);
    rchk(OFF_REF, 2, 16'h0500, "reference far reseed");
    end_sim();
  end
endmodule : test_css_regs
